/* File: rtl/cbm_pkg.sv */
// Overview of operation
// - Coherent flush, clean hit: invalidate everywhere
// - Coherent flush, dirty hit: write back, invalidate all
// - Coherent flush miss: remote dirty writes, all invalidate
// - Noncoherent flush: clean local invalidate, miss nothing
// - Noncoherent dirty flush: write back, then local invalidate
// - Write-through and inhibit bits never change maintenance
// - Maintenance access recorded only as a load
// - Coherent icache invalidate reaches every holding processor; UNIFIED skips the local one
// - Noncoherent icache invalidate stays local
// - Icache invalidate without load permission raises storage fault
// - Icache invalidate guaranteed only after instruction sync
// - Instruction sync waits for earlier instructions
// - Instruction sync holds fetch, discards prefetched instructions
// - Instruction sync stays local to executing processor
// - Software: store, barrier, invalidate, sync order
// - Software: multiprocessor unified uses flush not store
// - Four page attributes govern every access
// - W,I local only; guarded forbids speculative access
// - Coherent access signals the coherency mechanism
// - Attributes never stored with cached data
// - Translation off: data 0011, fetch 0001
// - Same-address accesses keep program order
// - Attribute pattern 11x left undefined
package cbm_pkg;
  // Bit positions inside page_access_attributes
  localparam int ATTR_W = 3;
  localparam int ATTR_I = 2;
  localparam int ATTR_M = 1;
  localparam int ATTR_G = 0;
  localparam int ATTR_WIDTH = 4;
  // Patterns used when translation is off
  localparam logic [3:0] ATTR_DATA_REAL = 4'h3;
  localparam logic [3:0] ATTR_INST_REAL = 4'h1;
  // Default effective address width
  localparam int ADDR_WIDTH = 64;

  // Pipeline maintenance commands
  typedef enum logic [1:0]
  {
    CBM_OP_DFLUSH = 2'b00,
    CBM_OP_IINV = 2'b01,
    CBM_OP_ISYNC = 2'b10
  } cbm_op_t;

  // Resolve attributes of an access from translation state
  function automatic logic [3:0] cbm_resolve(input logic [3:0] pte_attr,
                                             input logic trans_en,
                                             input logic fetch);
    if (trans_en)
    begin
      cbm_resolve = pte_attr;
    end
    else
    begin
      cbm_resolve = fetch ? ATTR_INST_REAL : ATTR_DATA_REAL;
    end
  endfunction
endpackage

/* File: rtl/cbm_if.sv */
`timescale 1ns/1ps
// Coherency link between the executing processor and the system
interface cbm_if #(parameter int AW = cbm_pkg::ADDR_WIDTH);
  logic req; // Broadcast request, held until done
  logic kind; // 0 data flush, 1 icache invalidate
  logic [AW-1:0] addr; // Target block address
  logic glob; // Access needs memory coherency
  logic done; // One-cycle completion from the system

  // Executing processor end
  modport dev (output req, output kind, output addr, output glob, input done);
  // System coherency end
  modport peer (input req, input kind, input addr, input glob, output done);
endinterface

/* File: rtl/cbm_attr.sv */
`timescale 1ns/1ps
// Attribute resolution for one access path
module cbm_attr
(
  input wire logic [3:0] i_pte_attr,
  input wire logic i_trans_en,
  input wire logic i_fetch,
  output logic [3:0] o_attr,
  output logic o_coh,
  output logic o_spec_ok
);
  import cbm_pkg::*;

  // Pure decode; nothing is kept with cached data
  always_comb
  begin
    // Unsupported 11x patterns pass through unchanged
    o_attr = cbm_resolve(i_pte_attr, i_trans_en, i_fetch);
    o_coh = o_attr[ATTR_M];
    o_spec_ok = ~o_attr[ATTR_G];
  end
endmodule

/* File: rtl/cbm_core.sv */
`timescale 1ns/1ps
// Executing processor maintenance engine
module cbm_core #(
  parameter int AW = cbm_pkg::ADDR_WIDTH,
  parameter bit UNIFIED = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Maintenance command from the pipeline
  input wire logic i_op_valid,
  input wire cbm_pkg::cbm_op_t i_op_code,
  input wire logic [AW-1:0] i_op_addr,
  input wire logic [3:0] i_op_attr,
  input wire logic i_load_ok,
  // Local cache lookup and write-back status
  input wire logic i_dc_hit,
  input wire logic i_dc_mod,
  input wire logic i_ic_hit,
  input wire logic i_wb_done,
  // Pipeline completion and translation state
  input wire logic i_older_done,
  input wire logic i_dtrans_en,
  input wire logic i_itrans_en,
  // Ordinary access path
  input wire logic i_acc_valid,
  input wire logic i_acc_fetch,
  input wire logic [3:0] i_acc_attr,
  output logic o_op_ready,
  output logic o_op_done,
  output logic o_dsi,
  output logic o_rec_load,
  output logic [AW-1:0] o_blk_addr,
  output logic o_dc_wb,
  output logic o_dc_inv,
  output logic o_ic_inv,
  output logic o_ic_inv_pend,
  output logic o_fetch_hold,
  output logic o_pf_flush,
  output logic o_acc_valid,
  output logic [3:0] o_acc_attr,
  output logic o_acc_coh,
  output logic o_acc_spec_ok,
  cbm_if.dev bus
);
  import cbm_pkg::*;

  // Engine states
  typedef enum logic [2:0]
  {
    CBM_IDLE = 3'b000,
    CBM_WB = 3'b001,
    CBM_INV = 3'b010,
    CBM_BCAST = 3'b011,
    CBM_SYNC = 3'b100,
    CBM_DONE = 3'b101
  } cbm_state_t;

  cbm_state_t state_r, state_nxt; // Engine state
  logic kind_r, kind_nxt; // 0 data flush, 1 icache invalidate
  logic coh_r, coh_nxt; // Target page is coherent
  logic [AW-1:0] addr_r, addr_nxt; // Target block
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic dsi_r, dsi_nxt;
  logic rec_r, rec_nxt;
  logic wb_r, wb_nxt;
  logic dinv_r, dinv_nxt;
  logic iinv_r, iinv_nxt;
  logic pend_r, pend_nxt; // Local icache invalidate not yet synced
  logic hold_r, hold_nxt;
  logic pff_r, pff_nxt;
  logic req_r, req_nxt;
  logic acc_v_r, acc_v_nxt;
  logic [3:0] acc_attr_r, acc_attr_nxt;
  logic acc_coh_r, acc_coh_nxt;
  logic acc_spec_r, acc_spec_nxt;
  logic take; // Command accepted this cycle
  logic op_coh; // Coherency bit of the target
  logic [3:0] acc_attr; // Resolved attributes of an access
  logic acc_coh;
  logic acc_spec;

  // Maintenance targets are data-side addresses
  cbm_attr u_op_attr (.i_pte_attr(i_op_attr), .i_trans_en(i_dtrans_en), .i_fetch(1'b0),
    .o_attr(), .o_coh(op_coh), .o_spec_ok());

  // Ordinary access resolution, fetch or data side
  cbm_attr u_acc_attr (.i_pte_attr(i_acc_attr),
    .i_trans_en(i_acc_fetch ? i_itrans_en : i_dtrans_en), .i_fetch(i_acc_fetch),
    .o_attr(acc_attr), .o_coh(acc_coh), .o_spec_ok(acc_spec));

  // Next state of the engine; one command at a time keeps order
  always_comb
  begin
    take = i_op_valid & ready_r;
    state_nxt = state_r;
    kind_nxt = kind_r;
    coh_nxt = coh_r;
    addr_nxt = addr_r;
    dsi_nxt = 1'b0;
    rec_nxt = 1'b0;
    unique case (state_r)
      CBM_IDLE:
      begin
        if (take)
        begin
          addr_nxt = i_op_addr;
          // Only the M bit steers the action, W and I are ignored
          coh_nxt = op_coh;
          kind_nxt = (i_op_code == CBM_OP_IINV);
          unique case (i_op_code)
            CBM_OP_DFLUSH:
            begin
              rec_nxt = 1'b1;
              // Dirty hit writes back first; a local miss broadcasts only when coherent
              state_nxt = (i_dc_hit && i_dc_mod) ? CBM_WB :
                          i_dc_hit ? CBM_INV :
                          op_coh ? CBM_BCAST : CBM_DONE;
            end
            CBM_OP_IINV:
            begin
              rec_nxt = i_load_ok;
              dsi_nxt = ~i_load_ok;
              // A unified cache skips the local invalidate but may still broadcast
              state_nxt = !i_load_ok ? CBM_DONE :
                          (!UNIFIED && i_ic_hit) ? CBM_INV :
                          op_coh ? CBM_BCAST : CBM_DONE;
            end
            CBM_OP_ISYNC:
            begin
              state_nxt = CBM_SYNC;
            end
            default:
            begin
              state_nxt = CBM_DONE;
            end
          endcase
        end
      end
      CBM_WB:
      begin
        // Invalidate only after the write-back is in memory
        if (i_wb_done)
        begin
          state_nxt = CBM_INV;
        end
      end
      CBM_INV:
      begin
        state_nxt = coh_r ? CBM_BCAST : CBM_DONE;
      end
      CBM_BCAST:
      begin
        if (bus.done)
        begin
          state_nxt = CBM_DONE;
        end
      end
      CBM_SYNC:
      begin
        // No link traffic is made for a sync
        if (i_older_done)
        begin
          state_nxt = CBM_DONE;
        end
      end
      CBM_DONE:
      begin
        state_nxt = CBM_IDLE;
      end
      default:
      begin
        state_nxt = CBM_IDLE;
      end
    endcase
    // Outputs follow the next state so they leave flops aligned
    ready_nxt = (state_nxt == CBM_IDLE);
    done_nxt = (state_nxt == CBM_DONE);
    wb_nxt = (state_nxt == CBM_WB);
    dinv_nxt = (state_nxt == CBM_INV) && !kind_nxt;
    iinv_nxt = (state_nxt == CBM_INV) && kind_nxt;
    req_nxt = (state_nxt == CBM_BCAST);
    hold_nxt = (state_nxt == CBM_SYNC);
    pff_nxt = (state_r == CBM_SYNC) && (state_nxt == CBM_DONE);
    // A new invalidate wins over a clear in the same cycle
    pend_nxt = iinv_nxt | (pend_r & ~pff_nxt);
    // Access attributes pass through, never held in cache state
    acc_v_nxt = i_acc_valid;
    acc_attr_nxt = acc_attr;
    acc_coh_nxt = i_acc_valid & acc_coh;
    acc_spec_nxt = acc_spec;
  end

  // Engine and output registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= CBM_IDLE;
      kind_r <= 1'b0;
      coh_r <= 1'b0;
      addr_r <= '0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      dsi_r <= 1'b0;
      rec_r <= 1'b0;
      wb_r <= 1'b0;
      dinv_r <= 1'b0;
      iinv_r <= 1'b0;
      pend_r <= 1'b0;
      hold_r <= 1'b0;
      pff_r <= 1'b0;
      req_r <= 1'b0;
      acc_v_r <= 1'b0;
      acc_attr_r <= 4'h0;
      acc_coh_r <= 1'b0;
      acc_spec_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      coh_r <= coh_nxt;
      addr_r <= addr_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      dsi_r <= dsi_nxt;
      rec_r <= rec_nxt;
      wb_r <= wb_nxt;
      dinv_r <= dinv_nxt;
      iinv_r <= iinv_nxt;
      pend_r <= pend_nxt;
      hold_r <= hold_nxt;
      pff_r <= pff_nxt;
      req_r <= req_nxt;
      acc_v_r <= acc_v_nxt;
      acc_attr_r <= acc_attr_nxt;
      acc_coh_r <= acc_coh_nxt;
      acc_spec_r <= acc_spec_nxt;
    end
  end

  assign o_op_ready = ready_r;
  assign o_op_done = done_r;
  assign o_dsi = dsi_r;
  assign o_rec_load = rec_r;
  assign o_blk_addr = addr_r;
  assign o_dc_wb = wb_r;
  assign o_dc_inv = dinv_r;
  assign o_ic_inv = iinv_r;
  assign o_ic_inv_pend = pend_r;
  assign o_fetch_hold = hold_r;
  assign o_pf_flush = pff_r;
  assign o_acc_valid = acc_v_r;
  assign o_acc_attr = acc_attr_r;
  assign o_acc_coh = acc_coh_r;
  assign o_acc_spec_ok = acc_spec_r;
  assign bus.req = req_r;
  assign bus.kind = kind_r;
  assign bus.addr = addr_r;
  assign bus.glob = req_r & coh_r;
endmodule

/* File: rtl/cbm_peer.sv */
`timescale 1ns/1ps
// Remote processor caches behind the coherency mechanism
module cbm_peer #(
  parameter int AW = cbm_pkg::ADDR_WIDTH
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Remote cache lookup for the broadcast address
  input wire logic i_rdc_hit,
  input wire logic i_rdc_mod,
  input wire logic i_ric_hit,
  input wire logic i_wb_done,
  output logic [AW-1:0] o_blk_addr,
  output logic o_rdc_wb,
  output logic o_rdc_inv,
  output logic o_ric_inv,
  cbm_if.peer bus
);
  import cbm_pkg::*;

  // Remote handler states
  typedef enum logic [1:0]
  {
    CBM_P_IDLE = 2'b00,
    CBM_P_WB = 2'b01,
    CBM_P_INV = 2'b10,
    CBM_P_ACK = 2'b11
  } cbm_pstate_t;

  cbm_pstate_t st_r, st_nxt;
  logic kind_r, kind_nxt; // Request kind latched at start
  logic [AW-1:0] addr_r, addr_nxt;
  logic wb_r, wb_nxt;
  logic dinv_r, dinv_nxt;
  logic iinv_r, iinv_nxt;
  logic done_r, done_nxt;

  // Next state of the remote handler
  always_comb
  begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    addr_nxt = addr_r;
    unique case (st_r)
      CBM_P_IDLE:
      begin
        if (bus.req && bus.glob)
        begin
          kind_nxt = bus.kind;
          addr_nxt = bus.addr;
          if (bus.kind)
          begin
            st_nxt = i_ric_hit ? CBM_P_INV : CBM_P_ACK;
          end
          else if (i_rdc_hit && i_rdc_mod)
          begin
            st_nxt = CBM_P_WB;
          end
          else
          begin
            st_nxt = i_rdc_hit ? CBM_P_INV : CBM_P_ACK;
          end
        end
      end
      CBM_P_WB:
      begin
        // Modified copy reaches memory before it is dropped
        if (i_wb_done)
        begin
          st_nxt = CBM_P_INV;
        end
      end
      CBM_P_INV:
      begin
        st_nxt = CBM_P_ACK;
      end
      CBM_P_ACK:
      begin
        st_nxt = CBM_P_IDLE;
      end
    endcase
    wb_nxt = (st_nxt == CBM_P_WB);
    dinv_nxt = (st_nxt == CBM_P_INV) && !kind_nxt;
    iinv_nxt = (st_nxt == CBM_P_INV) && kind_nxt;
    done_nxt = (st_nxt == CBM_P_ACK);
  end

  // Remote handler registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= CBM_P_IDLE;
      kind_r <= 1'b0;
      addr_r <= '0;
      wb_r <= 1'b0;
      dinv_r <= 1'b0;
      iinv_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      addr_r <= addr_nxt;
      wb_r <= wb_nxt;
      dinv_r <= dinv_nxt;
      iinv_r <= iinv_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_blk_addr = addr_r;
  assign o_rdc_wb = wb_r;
  assign o_rdc_inv = dinv_r;
  assign o_ric_inv = iinv_r;
  assign bus.done = done_r;
endmodule

/* File: verif/cbm_sva.sv */
`timescale 1ns/1ps
// Protocol watcher for the coherency link between the two ends
module cbm_sva #(parameter int AW = 64)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic req,
  input wire logic kind,
  input wire logic [AW-1:0] addr,
  input wire logic glob,
  input wire logic done
);
  // One clock domain, quiet while reset is low
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Every broadcast is flagged as needing coherency
  property p_glob_req;
    glob == req;
  endproperty
  a_glob_req: assert property (p_glob_req) else $error("glob differs from req");

  // Completion only answers a live request
  property p_done_req;
    done |-> req;
  endproperty
  a_done_req: assert property (p_done_req) else $error("done without req");

  // Completion is a single-cycle pulse
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  // Requester lets go right after completion
  property p_req_drop;
    done |=> !req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("req held after done");

  // Request and its qualifiers stay put until answered
  property p_req_hold;
    req && !done |=> req && $stable(addr) && $stable(kind);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req changed before done");

  // Remote side is idle when a request first shows, so no answer stands yet
  property p_min_wait;
    $rose(req) |-> !done;
  endproperty
  a_min_wait: assert property (p_min_wait) else $error("done too early");

  // Remote side answers within a bounded time
  property p_answer_bound;
    $rose(req) |-> ##[1:40] done;
  endproperty
  a_answer_bound: assert property (p_answer_bound) else $error("done never came");

  // A request is only withdrawn once answered
  property p_fell_after_done;
    $fell(req) |-> $past(done);
  endproperty
  a_fell_after_done: assert property (p_fell_after_done) else $error("req withdrawn early");

  // Main traffic kinds seen on the link
  c_flush: cover property (done && !kind);
  c_iinv: cover property (done && kind);
  c_round: cover property ($rose(req) ##[1:40] done);
endmodule

/* File: verif/cbm_tb.sv */
`timescale 1ns/1ps
module cbm_tb;
  import cbm_pkg::*;
  localparam int AW = 16;
  logic i_clk, i_rst_n, i_op_valid, i_load_ok, i_dc_hit, i_dc_mod, i_ic_hit, i_wb_done;
  logic i_older_done, i_dtrans_en, i_itrans_en, i_acc_valid, i_acc_fetch;
  logic i_rdc_hit, i_rdc_mod, i_ric_hit, r_wb_done;
  cbm_op_t i_op_code;
  logic [AW-1:0] i_op_addr;
  logic [3:0] i_op_attr, i_acc_attr, o_acc_attr;
  logic o_op_ready, o_op_done, o_dsi, o_rec_load, o_dc_wb, o_dc_inv, o_ic_inv, o_ic_inv_pend;
  logic o_fetch_hold, o_pf_flush, o_acc_valid, o_acc_coh, o_acc_spec_ok;
  logic o_rdc_wb, o_rdc_inv, o_ric_inv;
  logic [10:0] seen_f; // Events seen during the current command
  logic wb_order_bad = 1'b0; // Sticky: local invalidate ran ahead of write-back
  logic u_ic_inv; // Local icache invalidate of the unified-cache variant
  logic u_ic_seen = 1'b0; // Sticky: unified variant touched its icache
  logic [AW-1:0] core_addr, peer_addr; // Block addresses held by each end
  int n_fail, check_count;

  cbm_if #(.AW(AW)) link ();
  cbm_core #(.AW(AW), .UNIFIED(1'b0)) cbm_core_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_op_addr(i_op_addr),
    .i_op_attr(i_op_attr), .i_load_ok(i_load_ok), .i_dc_hit(i_dc_hit), .i_dc_mod(i_dc_mod),
    .i_ic_hit(i_ic_hit), .i_wb_done(i_wb_done), .i_older_done(i_older_done),
    .i_dtrans_en(i_dtrans_en), .i_itrans_en(i_itrans_en), .i_acc_valid(i_acc_valid),
    .i_acc_fetch(i_acc_fetch), .i_acc_attr(i_acc_attr), .o_op_ready(o_op_ready),
    .o_op_done(o_op_done), .o_dsi(o_dsi), .o_rec_load(o_rec_load), .o_blk_addr(core_addr),
    .o_dc_wb(o_dc_wb), .o_dc_inv(o_dc_inv), .o_ic_inv(o_ic_inv),
    .o_ic_inv_pend(o_ic_inv_pend), .o_fetch_hold(o_fetch_hold), .o_pf_flush(o_pf_flush),
    .o_acc_valid(o_acc_valid), .o_acc_attr(o_acc_attr), .o_acc_coh(o_acc_coh),
    .o_acc_spec_ok(o_acc_spec_ok), .bus(link));
  cbm_peer #(.AW(AW)) cbm_peer_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rdc_hit(i_rdc_hit),
    .i_rdc_mod(i_rdc_mod), .i_ric_hit(i_ric_hit), .i_wb_done(r_wb_done), .o_blk_addr(peer_addr),
    .o_rdc_wb(o_rdc_wb), .o_rdc_inv(o_rdc_inv), .o_ric_inv(o_ric_inv), .bus(link));
  cbm_sva #(.AW(AW)) cbm_sva_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .req(link.req),
    .kind(link.kind), .addr(link.addr), .glob(link.glob), .done(link.done));

  // Unified-cache variant on the same stimulus; its link answers at once
  cbm_if #(.AW(AW)) link_u ();
  assign link_u.done = link_u.req;
  cbm_core #(.AW(AW), .UNIFIED(1'b1)) cbm_core_u_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_op_addr(i_op_addr),
    .i_op_attr(i_op_attr), .i_load_ok(i_load_ok), .i_dc_hit(i_dc_hit), .i_dc_mod(i_dc_mod),
    .i_ic_hit(i_ic_hit), .i_wb_done(i_wb_done), .i_older_done(i_older_done),
    .i_dtrans_en(i_dtrans_en), .i_itrans_en(i_itrans_en), .i_acc_valid(i_acc_valid),
    .i_acc_fetch(i_acc_fetch), .i_acc_attr(i_acc_attr), .o_op_ready(), .o_op_done(),
    .o_dsi(), .o_rec_load(), .o_blk_addr(), .o_dc_wb(), .o_dc_inv(), .o_ic_inv(u_ic_inv),
    .o_ic_inv_pend(), .o_fetch_hold(), .o_pf_flush(), .o_acc_valid(), .o_acc_attr(),
    .o_acc_coh(), .o_acc_spec_ok(), .bus(link_u));

  // Free-running core clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Memory and pipeline responders: write-backs finish one cycle after start
  always @(posedge i_clk)
  begin
    i_wb_done <= o_dc_wb & ~i_wb_done;
    r_wb_done <= o_rdc_wb & ~r_wb_done;
    i_older_done <= o_fetch_hold;
  end

  // Collect events mid-cycle, where outputs are settled; idle cycles clear the set
  always @(negedge i_clk)
  begin
    if (o_op_ready)
    begin
      seen_f <= '0;
    end
    else
    begin
      seen_f <= seen_f | {link.req, o_dc_wb, o_dc_inv, o_ic_inv, o_rdc_wb, o_rdc_inv,
                          o_ric_inv, o_dsi, o_rec_load, o_pf_flush, o_fetch_hold};
    end
    if (o_dc_inv && i_dc_mod && (o_dc_wb || !seen_f[9]))
    begin
      wb_order_bad <= 1'b1;
    end
    if (u_ic_inv)
    begin
      u_ic_seen <= 1'b1;
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One command; st = {dhit, dmod, ihit, load_ok, rhit, rmod, rihit}
  task automatic do_op(input cbm_op_t code, input logic [3:0] attr, input logic [6:0] st,
                       input logic dtr);
    logic coh, fl, ii, ok, sy;
    logic [10:0] exp;
    int k;
    int lat;
    coh = dtr ? attr[ATTR_M] : ATTR_DATA_REAL[ATTR_M];
    fl = (code == CBM_OP_DFLUSH);
    ii = (code == CBM_OP_IINV);
    sy = (code == CBM_OP_ISYNC);
    ok = fl | (ii & st[3]);
    exp = {coh & ok, fl & st[6] & st[5], fl & st[6], ii & ok & st[4], fl & coh & st[2] & st[1],
           fl & coh & st[2], ii & ok & coh & st[0], ii & ~st[3], ok, sy, sy};
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op_code <= code;
    i_op_attr <= attr;
    i_op_addr <= i_op_addr + 16'h0040;
    {i_dc_hit, i_dc_mod, i_ic_hit, i_load_ok, i_rdc_hit, i_rdc_mod, i_ric_hit} <= st;
    i_dtrans_en <= dtr;
    k = 0;
    @(negedge i_clk);
    while (o_op_ready !== 1'b1 && k < 50)
    begin
      @(negedge i_clk);
      k++;
    end
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge i_clk);
      lat++;
    end
    while (o_op_done !== 1'b1 && lat < 100);
    if (k >= 50 || lat >= 100)
    begin
      n_fail++;
      report_and_stop();
    end
    @(posedge i_clk);
    check("events", seen_f, exp);
    check("blk_addr", {10'h000, core_addr == i_op_addr}, 11'h001);
    if (exp[10])
    begin
      check("peer_addr", {10'h000, peer_addr == i_op_addr}, 11'h001);
    end
    if (sy)
    begin
      // Hold, then the older-done answer, then done: three edges at the least
      check("sync_wait", {10'h000, lat >= 3}, 11'h001);
    end
  endtask

  // Ordinary access; resolved attributes appear one cycle later
  task automatic acc(input logic fetch, input logic tr, input logic [3:0] attr,
                     input logic [3:0] exp);
    @(posedge i_clk);
    i_acc_valid <= 1'b1;
    i_acc_fetch <= fetch;
    i_acc_attr <= attr;
    i_dtrans_en <= tr;
    i_itrans_en <= tr;
    @(posedge i_clk);
    i_acc_valid <= 1'b0;
    @(negedge i_clk);
    check("access", {4'h0, o_acc_valid, o_acc_coh, o_acc_spec_ok, o_acc_attr},
          {4'h0, 1'b1, exp[ATTR_M], ~exp[ATTR_G], exp});
  endtask

  // Main sequence
  initial
  begin
    {i_op_valid, i_load_ok, i_dc_hit, i_dc_mod, i_ic_hit} = '0;
    {i_acc_valid, i_acc_fetch, i_rdc_hit, i_rdc_mod, i_ric_hit} = '0;
    {i_dtrans_en, i_itrans_en} = 2'h3;
    i_op_code = CBM_OP_DFLUSH;
    i_op_addr = 16'h0100;
    i_op_attr = 4'h0;
    i_acc_attr = 4'h0;
    n_fail = 0;
    check_count = 0;
    i_rst_n = 1'b0;
    repeat (12) @(posedge i_clk);
    check("reset", {8'h00, o_op_ready, link.req, o_fetch_hold}, 11'h004);
    i_rst_n <= 1'b1;
    do_op(CBM_OP_DFLUSH, 4'h2, 7'b1000100, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h2, 7'b1100000, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h2, 7'b0000110, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h2, 7'b0000000, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h0, 7'b1000100, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h0, 7'b0000110, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h0, 7'b1100000, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'hA, 7'b1100110, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h5, 7'b1000000, 1'b1);
    do_op(CBM_OP_DFLUSH, 4'h0, 7'b0000110, 1'b0);
    do_op(CBM_OP_IINV, 4'h2, 7'b0011001, 1'b1);
    @(negedge i_clk);
    check("pending", {10'h000, o_ic_inv_pend}, 11'h001);
    do_op(CBM_OP_IINV, 4'h4, 7'b0011001, 1'b1);
    do_op(CBM_OP_IINV, 4'hB, 7'b0010001, 1'b1);
    do_op(CBM_OP_ISYNC, 4'h2, 7'b0000111, 1'b1);
    @(negedge i_clk);
    check("pending", {10'h000, o_ic_inv_pend}, 11'h000);
    acc(1'b0, 1'b0, 4'hC, ATTR_DATA_REAL);
    acc(1'b1, 1'b0, 4'hC, ATTR_INST_REAL);
    acc(1'b0, 1'b1, 4'hA, 4'hA);
    acc(1'b1, 1'b1, 4'h5, 4'h5);
    acc(1'b0, 1'b1, 4'hC, 4'hC);
    check("wb_order", {10'h000, wb_order_bad}, 11'h000);
    check("unified_ic", {10'h000, u_ic_seen}, 11'h000);
    report_and_stop();
  end
endmodule
